/* File: verilog/cdus_regs.svh */
`ifndef CDUS_REGS_SVH
`define CDUS_REGS_SVH
`define CDUS_CTL_EN_BIT      7
`define CDUS_CTL_SRC_HI      6
`define CDUS_CTL_SRC_LO      4
`define CDUS_CTL_FS_HI       1
`define CDUS_CTL_FS_LO       0
`define CDUS_CTL_RESET       8'h72
`define CDUS_CTL_WMASK       8'hf3
`define CDUS_HIGH_RESET      8'h00
`define CDUS_LOW_RESET       8'h00
`define CDUS_LOW_USED_MASK   8'hc0
`endif

/* File: verilog/cdus_pkg.sv */
package cdus_pkg;
  typedef enum logic [2:0] {
    CDUS_SRC_T0      = 3'h0,
    CDUS_SRC_T1      = 3'h1,
    CDUS_SRC_T2      = 3'h2,
    CDUS_SRC_T3      = 3'h3,
    CDUS_SRC_RISE    = 3'h4,
    CDUS_SRC_FALL    = 3'h5,
    CDUS_SRC_BOTH    = 3'h6,
    CDUS_SRC_ONWRITE = 3'h7
  } cdus_src_t;

  typedef enum logic [1:0] {
    CDUS_FS_HALF_MA = 2'h0,
    CDUS_FS_ONE_MA  = 2'h1,
    CDUS_FS_TWO_MA  = 2'h2
  } cdus_fs_t;
endpackage : cdus_pkg

/* File: verilog/cdus_edge_detect.sv */
module cdus_edge_detect (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // Two-stage synchroniser, then one stage of history for edges
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~prev_ff;
  assign fall  = ~sync_ff & prev_ff;
endmodule : cdus_edge_detect

/* File: verilog/cdus_dac_ctrl.sv */
`include "cdus_regs.svh"

module cdus_dac_ctrl (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ctl_wr,
  input  wire logic [7:0] ctl_wdata,
  input  wire logic       high_wr,
  input  wire logic [7:0] high_wdata,
  input  wire logic       low_wr,
  input  wire logic [7:0] low_wdata,
  input  wire logic [3:0] timer_ovf,
  input  wire logic       conversion_strobe_pin,
  output logic [7:0]      dac_control_reg,
  output logic [7:0]      data_high_byte,
  output logic [7:0]      data_low_byte,
  output logic [9:0]      dac_code,
  output logic [1:0]      full_scale_sel,
  output logic            dac_update,
  output logic            dac_enable_bit,
  output logic            bias_enable,
  output logic            pin_analog_connect,
  output logic            pin_digital_disable,
  output logic            pin_pullup_disable
);
  logic [7:0] ctl_ff;
  logic [7:0] high_ff;
  logic [7:0] low_ff;
  logic [9:0] latch_ff;
  logic       upd_ff;
  logic       strb_level;
  logic       strb_rise;
  logic       strb_fall;
  logic       nxt_update;
  cdus_pkg::cdus_src_t src;

  cdus_edge_detect u_strobe (
    .clk      (clk),
    .srst     (srst),
    .async_in (conversion_strobe_pin),
    .level    (strb_level),
    .rise     (strb_rise),
    .fall     (strb_fall)
  );

  function automatic logic [9:0] cdus_join(input logic [7:0] hi, input logic [7:0] lo);
    cdus_join = {hi, lo[7:6]};
  endfunction : cdus_join

  assign src = cdus_pkg::cdus_src_t'(ctl_ff[`CDUS_CTL_SRC_HI:`CDUS_CTL_SRC_LO]);

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl_ff <= `CDUS_CTL_RESET;
    end else if (ctl_wr) begin
      ctl_ff <= ctl_wdata & `CDUS_CTL_WMASK;
    end
  end

  // Staging registers; a write reaches the output only through an update, on the same edge (as a high write does in on-write mode) or a later one
  always_ff @(posedge clk) begin
    if (srst) begin
      high_ff <= `CDUS_HIGH_RESET;
      low_ff  <= `CDUS_LOW_RESET;
    end else begin
      if (high_wr) begin
        high_ff <= high_wdata;
      end
      if (low_wr) begin
        low_ff <= low_wdata;
      end
    end
  end

  always_comb begin
    case (src)
      cdus_pkg::CDUS_SRC_T0:      nxt_update = timer_ovf[0];
      cdus_pkg::CDUS_SRC_T1:      nxt_update = timer_ovf[1];
      cdus_pkg::CDUS_SRC_T2:      nxt_update = timer_ovf[2];
      cdus_pkg::CDUS_SRC_T3:      nxt_update = timer_ovf[3];
      cdus_pkg::CDUS_SRC_RISE:    nxt_update = strb_rise;
      cdus_pkg::CDUS_SRC_FALL:    nxt_update = strb_fall;
      cdus_pkg::CDUS_SRC_BOTH:    nxt_update = strb_rise | strb_fall;
      cdus_pkg::CDUS_SRC_ONWRITE: nxt_update = high_wr;
      default:                    nxt_update = 1'b0;
    endcase
  end

  // High write and latch copy on the same edge: the new high byte is taken
  always_ff @(posedge clk) begin
    if (srst) begin
      latch_ff <= 10'h000;
      upd_ff   <= 1'b0;
    end else begin
      upd_ff <= nxt_update;
      if (nxt_update) begin
        latch_ff <= cdus_join(high_wr ? high_wdata : high_ff,
                              low_wr ? low_wdata : low_ff);
      end
    end
  end

  assign dac_control_reg     = ctl_ff;
  assign data_high_byte      = high_ff;
  assign data_low_byte       = low_ff & `CDUS_LOW_USED_MASK;
  assign dac_code            = latch_ff;
  assign dac_update          = upd_ff;
  assign full_scale_sel      = ctl_ff[`CDUS_CTL_FS_HI:`CDUS_CTL_FS_LO];
  assign dac_enable_bit      = ctl_ff[`CDUS_CTL_EN_BIT];
  assign bias_enable         = ctl_ff[`CDUS_CTL_EN_BIT];
  assign pin_analog_connect  = ctl_ff[`CDUS_CTL_EN_BIT];
  assign pin_digital_disable = ctl_ff[`CDUS_CTL_EN_BIT];
  assign pin_pullup_disable  = ctl_ff[`CDUS_CTL_EN_BIT];

  default clocking cdus_cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_onwrite_upd: assert property (
    (src == cdus_pkg::CDUS_SRC_ONWRITE && high_wr) |=> dac_update && dac_code[9:2] == $past(high_wdata))
    else $error("high write did not update output");
  chk_low_held: assert property (
    (low_wr && !high_wr && src == cdus_pkg::CDUS_SRC_ONWRITE) |=> $stable(dac_code))
    else $error("low write changed output");
  chk_timer_hold: assert property (
    (src == cdus_pkg::CDUS_SRC_T2 && !timer_ovf[2]) |=> !dac_update)
    else $error("update without timer overflow");
  chk_timer_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_T1 && timer_ovf[1]) |=> dac_update ##1 1'b1)
    else $error("timer overflow missed");
  chk_join_copy: assert property (
    (dac_update && !$past(high_wr) && !$past(low_wr)) |->
      dac_code == {$past(high_ff), $past(low_ff[7:6])})
    else $error("latch copy wrong");
  chk_rise_only: assert property (
    (src == cdus_pkg::CDUS_SRC_RISE && $fell(strb_level)) |=> !dac_update)
    else $error("falling edge updated in rise mode");
  chk_strobe_lat: assert property (
    (src == cdus_pkg::CDUS_SRC_BOTH && $changed(strb_level)) |=> dac_update)
    else $error("strobe edge missed");
  chk_pin_enable: assert property (
    dac_enable_bit == (bias_enable && pin_analog_connect &&
                       pin_digital_disable && pin_pullup_disable))
    else $error("pin handover mismatch");
  chk_ctl_write: assert property (
    ctl_wr |=> full_scale_sel == $past(ctl_wdata[1:0]))
    else $error("full scale not written");
  chk_gpio_mode: assert property (
    (ctl_wr && !ctl_wdata[7]) |=>
      !(pin_analog_connect || pin_digital_disable || pin_pullup_disable))
    else $error("pin not returned to general use");
  chk_enable_write: assert property (
    (ctl_wr && ctl_wdata[7]) |=>
      (pin_analog_connect && pin_digital_disable && pin_pullup_disable))
    else $error("pin not handed to converter");
  chk_bias_follow: assert property (
    ctl_wr |=> bias_enable == $past(ctl_wdata[7]))
    else $error("bias enable does not follow converter enable");
  chk_src_write: assert property (
    ctl_wr |=> dac_control_reg[6:4] == $past(ctl_wdata[6:4]))
    else $error("update source not written");
  chk_t0_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_T0 && timer_ovf[0]) |=> dac_update)
    else $error("timer 0 overflow missed");
  chk_t2_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_T2 && timer_ovf[2]) |=> dac_update)
    else $error("timer 2 overflow missed");
  chk_t3_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_T3 && timer_ovf[3]) |=> dac_update)
    else $error("timer 3 overflow missed");
  chk_timer_still: assert property (
    (src == cdus_pkg::CDUS_SRC_T3 && !timer_ovf[3]) |=> $stable(dac_code))
    else $error("output changed without timer overflow");
  chk_onwrite_still: assert property (
    (src == cdus_pkg::CDUS_SRC_ONWRITE && !high_wr) |=> $stable(dac_code))
    else $error("output changed without high write");
  chk_strobe_still: assert property (
    (src == cdus_pkg::CDUS_SRC_BOTH && !$changed(strb_level)) |=> $stable(dac_code))
    else $error("output changed without strobe edge");
  chk_rise_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_RISE && $rose(strb_level)) |=> dac_update)
    else $error("rising strobe edge missed");
  chk_fall_fire: assert property (
    (src == cdus_pkg::CDUS_SRC_FALL && $fell(strb_level)) |=> dac_update)
    else $error("falling strobe edge missed");
  chk_fall_only: assert property (
    (src == cdus_pkg::CDUS_SRC_FALL && $rose(strb_level)) |=> !dac_update)
    else $error("rising edge updated in fall mode");
  chk_strobe_sync: assert property (
    (!$past(srst) && !$past(srst, 2)) |->
      strb_level == $past(conversion_strobe_pin, 2))
    else $error("strobe not two flops behind pin");
  chk_high_copy: assert property (
    (dac_update && $past(high_wr)) |->
      dac_code[9:2] == $past(high_wdata))
    else $error("coincident high write not copied");
  chk_low_copy: assert property (
    (dac_update && $past(low_wr)) |->
      dac_code[1:0] == $past(low_wdata[7:6]))
    else $error("coincident low write not copied");
  chk_low_mask: assert property (
    low_wr |=> data_low_byte == ($past(low_wdata) & `CDUS_LOW_USED_MASK))
    else $error("low byte field wrong");

  cov_onwrite: cover property (src == cdus_pkg::CDUS_SRC_ONWRITE && dac_update);
  cov_timer:   cover property (src == cdus_pkg::CDUS_SRC_T3 && dac_update);
  cov_fall:    cover property (src == cdus_pkg::CDUS_SRC_FALL && dac_update);
  cov_enable:  cover property ($rose(dac_enable_bit));
  cov_both:    cover property (src == cdus_pkg::CDUS_SRC_BOTH && dac_update);
endmodule : cdus_dac_ctrl

/* File: testbench/cdus_far_side.sv */
module cdus_far_side (
  input  wire logic  clk,
  output logic [3:0] timer_ovf,
  output logic       conversion_strobe_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] port_skip_reg;
  initial begin
    timer_ovf = 4'h0;
    conversion_strobe_pin = 1'b0;
    port_skip_reg = 8'h00;
  end
  // Software keeps the crossbar off the output pin before enabling
  task automatic skip_pin;
    port_skip_reg[1] = 1'b1;
  endtask : skip_pin
  task automatic ovf(input int n);
    @(negedge clk) timer_ovf = 4'(1 << n);
    @(negedge clk) timer_ovf = 4'h0;
  endtask : ovf
  // Pin moves off the clock edges, as a real external strobe would
  task automatic pin(input logic v);
    #3 conversion_strobe_pin = v;
  endtask : pin
endmodule : cdus_far_side

/* File: testbench/test_current_dac_update_scheduler.sv */
module test_current_dac_update_scheduler;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, srst = 1'b1, cw = 1'b0, hw = 1'b0, lw = 1'b0;
  logic [7:0] wd = 8'h00, ctl, hi, lo, h, l;
  logic [9:0] code, n_upd;
  logic [1:0] fs;
  logic       upd, en, bias, pac, pdd, ppd, strobe;
  logic [3:0] ovf;
  int         miscompares = 0, n_compared = 0;
  int         exp_q[$] = {0};
  always #5 clk = ~clk;
  cdus_far_side cdus_far_side_i (.clk(clk), .timer_ovf(ovf), .conversion_strobe_pin(strobe));
  cdus_dac_ctrl cdus_dac_ctrl_i (.clk(clk), .srst(srst), .ctl_wr(cw), .ctl_wdata(wd),
    .high_wr(hw), .high_wdata(wd), .low_wr(lw), .low_wdata(wd), .timer_ovf(ovf),
    .conversion_strobe_pin(strobe), .dac_control_reg(ctl), .data_high_byte(hi),
    .data_low_byte(lo), .dac_code(code), .full_scale_sel(fs), .dac_update(upd),
    .dac_enable_bit(en), .bias_enable(bias), .pin_analog_connect(pac),
    .pin_digital_disable(pdd), .pin_pullup_disable(ppd));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    {cw, hw, lw} = s;
    wd = d;
    @(negedge clk);
    {cw, hw, lw} = 3'b000;
  endtask : wr
  task automatic after(input logic e);
    if (e) exp_q.push_back(int'({h, l[7:6]}));
    chk(10'(upd), 10'(e));
    chk(code, 10'(exp_q[$]));
    @(negedge clk);
    chk(10'(upd), 10'h000);
  endtask : after
  task automatic edge_chk(input logic v, input logic e);
    n_upd = 10'h000;
    cdus_far_side_i.pin(v);
    repeat (8) begin
      @(negedge clk);
      n_upd = n_upd + 10'(upd);
    end
    if (e) exp_q.push_back(int'({h, l[7:6]}));
    chk(n_upd, 10'(e));
    chk(code, 10'(exp_q[$]));
  endtask : edge_chk
  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(77));
    repeat (8) @(negedge clk);
    srst = 1'b0;
    chk(10'(ctl), 10'h072);
    chk({3'h0, en, bias, pac, pdd, ppd, fs}, 10'h002);
    l = 8'($urandom);
    h = 8'($urandom);
    wr(3'b001, l);
    chk(code, 10'h000);
    wr(3'b010, h);
    after(1'b1);
    h = 8'($urandom);
    wr(3'b010, h);
    after(1'b1);
    cdus_far_side_i.skip_pin();
    for (int m = 0; m < 7; m++) begin
      wr(3'b100, {1'b1, 3'(m), 2'b11, 2'(m % 3)});
      chk(10'(ctl), 10'({1'b1, 3'(m), 2'b00, 2'(m % 3)}));
      chk(10'(fs), 10'(m % 3));
      chk(10'({en, bias, pac, pdd, ppd}), 10'h01f);
      chk(10'({cdus_far_side_i.port_skip_reg[1], pdd}), 10'h003);
      l = 8'($urandom);
      h = 8'($urandom);
      wr(3'b001, l);
      wr(3'b010, h);
      chk(10'(lo), 10'(l & 8'hc0));
      chk(10'(hi), 10'(h));
      after(1'b0);
      if (m < 4) begin
        cdus_far_side_i.ovf((m + 1) % 4);
        after(1'b0);
        cdus_far_side_i.ovf(m);
        after(1'b1);
      end else begin
        edge_chk(1'b1, m != 5);
        h = 8'($urandom);
        wr(3'b010, h);
        edge_chk(1'b0, m != 4);
      end
    end
    wr(3'b100, 8'h72);
    chk(10'({en, bias, pac, pdd, ppd}), 10'h000);
    summarize();
  end
endmodule : test_current_dac_update_scheduler
